// ### verilog/lbct_ctrl.sv
// Local bus command, ready and transceiver sequencing controller
//
// Summary of operation
// [RL1] Command strobe turns on entering command state
// [RL2] Command strobe turns off leaving final command state
// [RL3] Delay input postpones command, cycle length unchanged
// [RL4] Each wait keeps command two more clocks
// [RL5] Ready comes from address decode, maybe commands
// [RL6] Async ready never gated by a command
// [RL7] Zero-wait sync ready only undelayed command
// [RL8] With waits, ready may use delayed command
// [RL9] Each wait gives ready logic two clocks
// [RL10] Read command turns on early in command
// [RL11] Read: direction receive first, enable afterwards
// [RL12] Each read wait widens data windows two clocks
// [RL13] Interrupt acknowledge runs two back-to-back cycles
// [RL14] Direction back to transmit after reads only
// [RL15] Write enables transceiver before write command
// [RL16] No ready at command end repeats command
`timescale 1ns/1ps
`default_nettype none
`include "lbct_map.svh"
module lbct_ctrl
   import lbct_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Cycle request from the processor side
   input  wire logic       cycle_request,
   input  wire lbct_kind_t cycle_kind,
   // Pins from the far side, active low ready
   input  wire logic       async_ready_input_b,
   input  wire logic       sync_ready_input_b,
   input  wire logic       command_delay_input,
   // Command strobes, active low
   output logic            memory_read_strobe_b,
   output logic            memory_write_strobe_b,
   output logic            io_read_strobe_b,
   output logic            io_write_strobe_b,
   output logic            interrupt_acknowledge_cycle_b,
   // Data transceiver control
   output logic            transceiver_direction,
   output logic            transceiver_enable,
   // Cycle status
   output logic            bus_busy,
   output logic            cycle_done
);
   lbct_state_t state;        // Current bus state
   lbct_state_t next_state;   // Next bus state
   logic        ph;           // Clock within a state
   logic        next_ph;      // Next clock within a state
   lbct_kind_t  kind;         // Kind of the running cycle
   lbct_kind_t  next_kind;    // Next kind
   logic        dly;          // Command delay taken for this cycle
   logic        next_dly;     // Next delay flag
   logic        second;       // Second acknowledge cycle running
   logic        next_second;  // Next second flag
   logic        cmd;          // Command active, active high
   logic        next_cmd;     // Next command level
   logic        next_dir;     // Next transceiver direction
   logic        next_en;      // Next transceiver enable
   logic        next_done;    // Next completion pulse
   logic        is_read;      // Running cycle takes data in
   logic        ready;        // Either ready input active
   lbct_sync_if #(.W(`LBCT_PIN_W)) pins ();  // Synchroniser carrier

   // Bring pin inputs onto sys_clk
   assign pins.raw[`LBCT_PIN_ASYNC_READY_INPUT] = async_ready_input_b;
   assign pins.raw[`LBCT_PIN_SYNC_READY_INPUT] = sync_ready_input_b;
   assign pins.raw[`LBCT_PIN_DLY]  = command_delay_input;

   lbct_pin_sync #(
      .W       (`LBCT_PIN_W),
      .RST_VAL (`LBCT_PIN_RST)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .pins    (pins)
   );

   // Far side builds ready from decode; either ready input ends the cycle [RL5] [RL6]
   assign ready   = !pins.clean[`LBCT_PIN_ASYNC_READY_INPUT] || !pins.clean[`LBCT_PIN_SYNC_READY_INPUT];
   // Acknowledge cycles read the vector like a read
   assign is_read = (kind == LBCT_MEM_RD) || (kind == LBCT_IO_RD) || (kind == LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE);

   // Sequencer next values
   always_comb begin
      next_state  = state;
      next_ph     = ph;
      next_kind   = kind;
      next_dly    = dly;
      next_second = second;
      next_cmd    = cmd;
      next_dir    = transceiver_direction;
      next_en     = transceiver_enable;
      next_done   = 1'b0;
      case (state)
         LBCT_IDLE: begin
            // Take a new cycle only while idle
            if (cycle_request) begin
               next_state  = LBCT_STATUS;
               next_ph     = `LBCT_PH_FIRST;
               next_kind   = cycle_kind;
               next_second = 1'b0;
            end
         end
         LBCT_STATUS: begin
            if (ph == `LBCT_PH_FIRST) begin
               next_ph = `LBCT_PH_SECOND;
               if (is_read) begin
                  next_dir = `LBCT_DIR_RX;  // [RL11]
               end else begin
                  next_en = 1'b1;  // [RL15]
               end
            end else begin
               // Enter command state; delay only moves the strobe [RL3]
               next_ph    = `LBCT_PH_FIRST;
               next_state = LBCT_COMMAND;
               next_dly   = pins.clean[`LBCT_PIN_DLY];
               next_cmd   = !pins.clean[`LBCT_PIN_DLY];  // [RL1] [RL10]
               if (is_read) begin
                  next_en = 1'b1;  // [RL11]
               end
            end
         end
         LBCT_COMMAND: begin
            if (ph == `LBCT_PH_FIRST) begin
               next_ph  = `LBCT_PH_SECOND;
               next_cmd = 1'b1;  // [RL3]
            end else begin
               next_ph = `LBCT_PH_FIRST;
               if (ready) begin
                  // Final command state ends [RL2]
                  next_cmd  = 1'b0;
                  next_en   = 1'b0;
                  next_dir  = `LBCT_DIR_TX;  // [RL14]
                  next_done = 1'b1;
                  if ((kind == LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE) && !second) begin
                     next_state  = LBCT_STATUS;  // [RL13]
                     next_second = 1'b1;
                  end else begin
                     next_state = LBCT_IDLE;
                  end
               end else begin
                  // Wait state: command held two more clocks [RL16] [RL4] [RL9] [RL12]
                  next_state = LBCT_COMMAND;
                  next_dly   = 1'b0;
               end
            end
         end
         default: begin
            next_state = LBCT_IDLE;
            next_cmd   = 1'b0;
            next_en    = 1'b0;
            next_dir   = `LBCT_DIR_TX;
         end
      endcase
   end

   // Sequencer registers, strobes decoded from the next command level
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state                         <= LBCT_IDLE;
         ph                            <= `LBCT_PH_FIRST;
         kind                          <= LBCT_MEM_RD;
         dly                           <= 1'b0;
         second                        <= 1'b0;
         cmd                           <= 1'b0;
         transceiver_direction         <= `LBCT_DIR_TX;
         transceiver_enable            <= 1'b0;
         cycle_done                    <= 1'b0;
         bus_busy                      <= 1'b0;
         memory_read_strobe_b          <= `LBCT_CMD_IDLE;
         memory_write_strobe_b         <= `LBCT_CMD_IDLE;
         io_read_strobe_b              <= `LBCT_CMD_IDLE;
         io_write_strobe_b             <= `LBCT_CMD_IDLE;
         interrupt_acknowledge_cycle_b <= `LBCT_CMD_IDLE;
      end else begin
         state                         <= next_state;
         ph                            <= next_ph;
         kind                          <= next_kind;
         dly                           <= next_dly;
         second                        <= next_second;
         cmd                           <= next_cmd;
         transceiver_direction         <= next_dir;
         transceiver_enable            <= next_en;
         cycle_done                    <= next_done;
         bus_busy                      <= (next_state != LBCT_IDLE);
         memory_read_strobe_b          <= !(next_cmd && (next_kind == LBCT_MEM_RD));
         memory_write_strobe_b         <= !(next_cmd && (next_kind == LBCT_MEM_WR));
         io_read_strobe_b              <= !(next_cmd && (next_kind == LBCT_IO_RD));
         io_write_strobe_b             <= !(next_cmd && (next_kind == LBCT_IO_WR));
         interrupt_acknowledge_cycle_b <= !(next_cmd && (next_kind == LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE));
      end
   end

   // Checks on the sequencing
   logic in_cmd;  // Command state flag for the checks
   logic is_wr;   // Write cycle flag for the checks
   assign in_cmd = (state == LBCT_COMMAND);
   assign is_wr  = (kind == LBCT_MEM_WR) || (kind == LBCT_IO_WR);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   property p_cmd_on;
      $rose(in_cmd) && !dly |-> cmd;
   endproperty
   a_cmd_on: assert property (p_cmd_on) else $error("command not on at command state"); // [RL1]

   property p_cmd_off;
      $fell(in_cmd) |-> !cmd && cycle_done;
   endproperty
   a_cmd_off: assert property (p_cmd_off) else $error("command still on after cycle"); // [RL2]

   property p_delay;
      $rose(in_cmd) && dly |-> !cmd ##1 (cmd && in_cmd);
   endproperty
   a_delay: assert property (p_delay) else $error("delayed command misplaced"); // [RL3]

   property p_wait;
      in_cmd && ph && !ready |=> (in_cmd && cmd) [*2];
   endproperty
   a_wait: assert property (p_wait) else $error("wait state did not hold command"); // [RL4]

   property p_read_order;
      $rose(transceiver_enable) && is_read |->
         transceiver_direction == `LBCT_DIR_RX && $past(transceiver_direction) == `LBCT_DIR_RX;
   endproperty
   a_read_order: assert property (p_read_order) else $error("enable before receive"); // [RL11]

   property p_dir_end;
      cycle_done |-> transceiver_direction == `LBCT_DIR_TX;
   endproperty
   a_dir_end: assert property (p_dir_end) else $error("direction not transmit at end"); // [RL14]

   property p_write_dir;
      bus_busy && is_wr |-> transceiver_direction == `LBCT_DIR_TX;
   endproperty
   a_write_dir: assert property (p_write_dir) else $error("direction moved in write"); // [RL14]

   property p_write_early;
      !memory_write_strobe_b && $past(memory_write_strobe_b) |-> $past(transceiver_enable);
   endproperty
   a_write_early: assert property (p_write_early) else $error("write enable late"); // [RL15]

   // The closing pulse of a pair follows the first one four clocks earlier
   property p_interrupt_acknowledge_cycle_pair;
      cycle_done && kind == LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE && !bus_busy |-> $past(cycle_done, 4);
   endproperty
   a_interrupt_acknowledge_cycle_pair: assert property (p_interrupt_acknowledge_cycle_pair) else $error("acknowledge pair broken"); // [RL13]

   property p_zero_wait;
      $rose(in_cmd) && !dly ##1 ready |-> cmd ##1 !cmd;
   endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("zero wait pulse length wrong"); // [RL16]

   c_read: cover property ($rose(transceiver_enable) && is_read);
   c_write_dly: cover property ($rose(in_cmd) && dly && is_wr);
   c_wait: cover property (in_cmd && ph && !ready);
   c_interrupt_acknowledge_cycle: cover property (cycle_done && second);
endmodule : lbct_ctrl
`default_nettype wire

// ### verilog/lbct_map.svh
// Constants for the local bus command timing block
`ifndef LBCT_MAP_SVH
`define LBCT_MAP_SVH
`define LBCT_PH_FIRST    1'b0
`define LBCT_PH_SECOND   1'b1
`define LBCT_CMD_IDLE    1'b1
`define LBCT_DIR_TX      1'b1
`define LBCT_DIR_RX      1'b0
`define LBCT_PIN_W       3
`define LBCT_PIN_ASYNC_READY_INPUT    0
`define LBCT_PIN_SYNC_READY_INPUT    1
`define LBCT_PIN_DLY     2
`define LBCT_PIN_RST     3'h3
`endif

// ### verilog/lbct_pkg.sv
// Types for the local bus command timing block
package lbct_pkg;
   // Bus cycle states
   typedef enum logic [1:0] {
      LBCT_IDLE,
      LBCT_STATUS,
      LBCT_COMMAND
   } lbct_state_t;
   // Kinds of bus cycle
   typedef enum logic [2:0] {
      LBCT_MEM_RD,
      LBCT_MEM_WR,
      LBCT_IO_RD,
      LBCT_IO_WR,
      LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE
   } lbct_kind_t;
endpackage : lbct_pkg

// ### verilog/lbct_sync_if.sv
// Carrier between the controller and its pin synchroniser
`timescale 1ns/1ps
`default_nettype none
interface lbct_sync_if #(parameter int W = 3);
   logic [W-1:0] raw;    // Pin levels as they arrive
   logic [W-1:0] clean;  // Settled levels on sys_clk
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface : lbct_sync_if
`default_nettype wire

// ### verilog/lbct_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module lbct_pin_sync #(
   parameter int         W       = 3,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_b,
   // Pin side and settled side
   lbct_sync_if.sync pins
);
   logic [W-1:0] s1;          // First stage, read only by s2
   logic [W-1:0] s2;          // Second stage
   logic [W-1:0] s3;          // Third stage
   logic [W-1:0] clean;       // Accepted level
   logic [W-1:0] next_clean;  // Next accepted level

   // A bit changes once stages two and three agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         next_clean[i] = (s2[i] == s3[i]) ? s3[i] : clean[i];
      end
   end

   // Register the chain
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         s1    <= RST_VAL;
         s2    <= RST_VAL;
         s3    <= RST_VAL;
         clean <= RST_VAL;
      end else begin
         s1    <= pins.raw;
         s2    <= s1;
         s3    <= s2;
         clean <= next_clean;
      end
   end

   assign pins.clean = clean;
endmodule : lbct_pin_sync
`default_nettype wire

// ### test/lbct_far_side.sv
// Far-side device model: ready produced from address decode
`timescale 1ns/1ps
`default_nettype none
module lbct_far_side (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Decode and behaviour controls
   input  wire logic       sel,
   input  wire logic       always_rdy,
   input  wire logic       use_async,
   input  wire logic [3:0] lat,
   // Ready pins, active low
   output logic            async_ready_input_b,
   output logic            sync_ready_input_b
);
   logic [3:0] cnt;  // Clocks since the device was selected
   logic       rdy;  // Device able to end the cycle
   // Count selected clocks, saturating
   always_ff @(posedge sys_clk) begin
      if (!rst_b || !sel) begin
         cnt <= 4'h0;
      end else if (cnt != 4'hF) begin
         cnt <= cnt + 4'h1;
      end
   end
   // Ready from decode alone; each wait asks two more clocks
   assign rdy = always_rdy || (sel && cnt >= lat);
   // No command ever qualifies ready, so both wait regimes stay legal
   // Only the chosen pin answers; the other rests at its pulled-up level
   assign async_ready_input_b = !(rdy && use_async);
   assign sync_ready_input_b  = !(rdy && !use_async);
endmodule : lbct_far_side
`default_nettype wire

// ### test/tb_lbct_ctrl.sv
// Self-checking bench for the local bus command controller
`timescale 1ns/1ps
`default_nettype none
module tb_lbct_ctrl;
   import lbct_pkg::*;
   // Design and model hookup
   logic       sys_clk, rst_b, cycle_request, command_delay_input;
   logic       async_b, sync_b, always_rdy, use_async;
   logic [3:0] lat;
   lbct_kind_t cycle_kind;
   logic [4:0] stb_b;
   logic       dir, en, bus_busy, cycle_done;
   wire  logic sel = bus_busy & ~cycle_done;  // Decode drops at cycle end
   // Bench bookkeeping
   int         num_errors = 0;
   int         checks     = 0;
   int         seed       = 62336;
   int         cyc        = 0;
   lbct_kind_t k;
   int         w, n;

   lbct_ctrl dut_u (
      .sys_clk(sys_clk), .rst_b(rst_b), .cycle_request(cycle_request),
      .cycle_kind(cycle_kind), .async_ready_input_b(async_b),
      .sync_ready_input_b(sync_b), .command_delay_input(command_delay_input),
      .memory_read_strobe_b(stb_b[0]), .memory_write_strobe_b(stb_b[1]),
      .io_read_strobe_b(stb_b[2]), .io_write_strobe_b(stb_b[3]),
      .interrupt_acknowledge_cycle_b(stb_b[4]), .transceiver_direction(dir),
      .transceiver_enable(en), .bus_busy(bus_busy), .cycle_done(cycle_done));

   lbct_far_side far_u (
      .sys_clk(sys_clk), .rst_b(rst_b), .sel(sel), .always_rdy(always_rdy),
      .use_async(use_async), .lat(lat), .async_ready_input_b(async_b),
      .sync_ready_input_b(sync_b));

   // Compare one value and count it
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Print the counts and the verdict, then stop
   task automatic summarize;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize

   // Run n chained cycles of one kind with w waits and delay d, then check
   task automatic run_op(input lbct_kind_t kd, input int wt, input logic d, input int nc);
      int   nb = 0;
      int   ns = 0;
      int   nf = 0;
      int   no = 0;
      int   nd = 0;
      int   ne = 0;
      int   bad = 0;
      int   dn = 0;
      logic prev = 1'b1;
      logic rd;
      rd = kd inside {LBCT_MEM_RD, LBCT_IO_RD, LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE};
      always_rdy = (wt == 0);
      use_async = 1'($random(seed));
      lat = 4'(2 * wt - 1);
      command_delay_input = d;
      repeat (4) @(negedge sys_clk);
      cycle_kind = kd;
      cycle_request = 1'b1;
      @(negedge sys_clk);
      // Request stays up while busy, so later edges test refusal
      do begin
         nb += int'(bus_busy === 1'b1);
         ns += int'(stb_b[kd] === 1'b0);
         nf += int'(prev === 1'b1 && stb_b[kd] === 1'b0);
         no += int'((stb_b | (5'h1 << kd)) !== 5'h1F);
         nd += int'(dir === 1'b0);
         ne += int'(en === 1'b1);
         bad += int'(rd && en === 1'b1 && dir !== 1'b0);
         dn += int'(cycle_done === 1'b1);
         if (dn >= nc) begin
            cycle_request = 1'b0;
         end
         prev = stb_b[kd];
         @(negedge sys_clk);
      end while (dn < ((kd == LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE) ? 2 * nc : nc) && nb < 60);
      if (kd == LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE) begin
         chk(nb, 8);
         chk(ns, 2 * (2 - int'(d)));
         chk(nf, 2);
         chk(nd, 6);
         chk(ne, 4);
      end else begin
         chk(nb, nc * (4 + 2 * wt));
         chk(nf, nc);
         chk(ns, nc * (2 + 2 * wt - int'(d)));
         chk(nd, rd ? nc * (3 + 2 * wt) : 0);
         chk(ne, nc * (rd ? 2 + 2 * wt : 3 + 2 * wt));
      end
      chk(no, 0);
      chk(bad, 0);
      chk(dir, 1);
      $display("test end kind=%0d waits=%0d delay=%0d count=%0d", kd, wt, d, nc);
   endtask : run_op

   // Free-running clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Cut a hang short
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         summarize();
      end
   end

   // Main sequence: every kind, corners, then random cycles
   initial begin
      rst_b = 1'b0;
      cycle_request = 1'b0;
      cycle_kind = LBCT_MEM_RD;
      command_delay_input = 1'b0;
      always_rdy = 1'b1;
      use_async = 1'b0;
      lat = 4'h0;
      repeat (3) @(negedge sys_clk);
      rst_b = 1'b1;
      for (int i = 0; i < 5; i++) begin
         run_op(lbct_kind_t'(i), 0, 1'b0, 1);
      end
      run_op(LBCT_MEM_WR, 2, 1'b1, 1);
      run_op(LBCT_IO_RD, 1, 1'b0, 2);
      run_op(LBCT_MEM_RD, 0, 1'b1, 2);
      for (int i = 0; i < 14; i++) begin
         k = lbct_kind_t'($unsigned($random(seed)) % 5);
         w = (k == LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE) ? 0 : $unsigned($random(seed)) % 3;
         n = (k == LBCT_INTERRUPT_ACKNOWLEDGE_CYCLE) ? 1 : 1 + $unsigned($random(seed)) % 2;
         run_op(k, w, 1'($random(seed)), n);
      end
      summarize();
   end
endmodule : tb_lbct_ctrl
`default_nettype wire
